//--- rtl/ext_bus_idle_cycle_insert.sv
// external bus cycle sequencer with idle-cycle insertion and register slave
// Summary of operation
// - after space 1/5 read, idle before write there or access elsewhere
// - space 1/5 idle field codes 00..11 give zero to three idle cycles
// - after space 0/4 read, idle before write there or access elsewhere
// - space 0/4 idle field codes 00..11 give zero to three idle cycles
// - continuous bit set: repeated space 3 access gets one idle, select off
// - same single idle for 3 then 7, 7 then 7, and 7 then 3
// - continuous bit 0 inserts nothing, 1 inserts exactly one idle cycle
// - idle fields and continuous bit reset to ones and are read/write
// - where both idle sources apply, the larger count is used, never the sum
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module ext_bus_idle_cycle_insert
  import idle_insert_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic access_valid,
  input wire access_req_s access,
  output logic access_ready,
  output ext_bus_s ext_bus
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    state_e st;
    ctrl_s ctrl;
    logic prev_valid;
    access_req_s prev;
    logic [GAP_W-1:0] elapsed;
    logic acc_ready;
    ext_bus_s ext;
    logic aw_held;
    logic [AW-1:0] aw_addr;
    logic w_held;
    logic [CTRL_W-1:0] wbuf;
    logic [CTRL_LANES-1:0] wlanes;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_s;

  regs_s r;
  regs_s next_r;
  logic take;
  logic [GAP_W-1:0] gap_need;
  logic [CTRL_W-1:0] cv;

  idle_gap_calc gap_calc (
    .prev_valid(r.prev_valid),
    .prev(r.prev),
    .next_acc(access),
    .ctrl(r.ctrl),
    .gap(gap_need)
  );

  function automatic logic [AW-LANE_BITS-1:0] word_of(input logic [AW-1:0] a);
    word_of = a[AW-1:LANE_BITS];
  endfunction

  function automatic logic is_addr(input logic [AW-1:0] a, input logic [7:0] c);
    is_addr = word_of(a) == word_of(AW'(c));
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_r = r;
    cv = r.ctrl;
    take = access_valid && r.acc_ready;

    // access sequencer: two strobe cycles per access
    unique case (r.st)
      ST_IDLE: begin
        if (take) begin
          next_r.st = ST_ACC1;
        end
      end
      ST_ACC1: begin
        next_r.st = ST_ACC2;
      end
      ST_ACC2: begin
        next_r.st = take ? ST_ACC1 : ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    if (take) begin
      next_r.prev_valid = 1'b1;
      next_r.prev = access;
    end

    // idle cycles already on the bus since the last strobe
    if (next_r.st != ST_IDLE) begin
      next_r.elapsed = '0;
    end else if (r.elapsed != GAP_MAX) begin
      next_r.elapsed = r.elapsed + 1'b1;
    end

    // a request is offered only once the required gap has elapsed
    next_r.acc_ready = access_valid && !take && next_r.st != ST_ACC1
      && gap_need <= next_r.elapsed;

    next_r.ext = EXT_QUIET;
    if (next_r.st != ST_IDLE) begin
      next_r.ext.select_n = space_select_s'(~(8'h01 << next_r.prev.space));
      next_r.ext.read_n = next_r.prev.write;
      next_r.ext.write_n = !next_r.prev.write;
    end

    // register write path
    if (awvalid && r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_held = 1'b1;
      next_r.wbuf = wdata[CTRL_W-1:0];
      next_r.wlanes = wstrb[CTRL_LANES-1:0];
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (next_r.aw_held && next_r.w_held && !next_r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (is_addr(next_r.aw_addr, CTRL_ADDR)) begin
        for (int i = 0; i < CTRL_LANES; i++) begin
          if (next_r.wlanes[i]) begin
            cv[i*BYTE_W +: BYTE_W] = next_r.wbuf[i*BYTE_W +: BYTE_W];
          end
        end
        next_r.ctrl = ctrl_s'(cv & CTRL_WR_MASK);
      end else if (!is_addr(next_r.aw_addr, STATUS_ADDR)) begin
        next_r.bresp = RESP_DECERR;
      end
    end
    next_r.awready = !next_r.aw_held && !next_r.bvalid;
    next_r.wready = !next_r.w_held && !next_r.bvalid;

    // register read path
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = '0;
      if (is_addr(araddr, CTRL_ADDR)) begin
        next_r.rdata = 32'(r.ctrl);
      end else if (is_addr(araddr, STATUS_ADDR)) begin
        next_r.rdata = 32'({r.st, r.elapsed, r.prev_valid, r.prev});
      end else begin
        next_r.rresp = RESP_DECERR;
      end
    end
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= ctrl_s'(CTRL_RESET);
      r.elapsed <= GAP_MAX;
      r.ext <= EXT_QUIET;
    end else begin
      r <= next_r;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign access_ready = r.acc_ready;
  assign ext_bus = r.ext;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic quiet;
  assign quiet = ext_bus == EXT_QUIET;

  sequence s_rd_end(logic [GRP_W-1:0] grp);
    r.st == ST_ACC2 && r.prev_valid && !r.prev.write
      && r.prev.space[GRP_W-1:0] == grp;
  endsequence

  sequence s_end_in(logic [2:0] sp);
    r.st == ST_ACC2 && r.prev_valid && r.prev.space == sp;
  endsequence

  sequence s_gap_then_access(logic sel_n);
    quiet ##1 !sel_n;
  endsequence

  AST_IDLE_QUIET: assert property (r.st == ST_IDLE |-> quiet)
    else $error("bus not quiet during idle cycle");

  AST_SP15_WRITE_GAP: assert property (s_rd_end(GRP_15) ##0 (access_valid
      && access.write && access.space == SP_ONE
      && {r.ctrl.idle_count_sp15_hi, r.ctrl.idle_count_sp15_lo} == 2'h3)
      |=> quiet [*3] ##1 !ext_bus.select_n.space_one_select_n)
    else $error("space 1 write after read did not get three idle cycles");

  AST_SP04_OTHER_GAP: assert property (s_rd_end(GRP_04) ##0 (access_valid
      && access.space == SP_TWO
      && {r.ctrl.idle_count_sp04_hi, r.ctrl.idle_count_sp04_lo} == 2'h2)
      |=> quiet [*2] ##1 !ext_bus.select_n.space_two_select_n)
    else $error("space change after space 0 read did not get two idle cycles");

  AST_SP3_REPEAT_GAP: assert property (s_end_in(SP_THREE) ##0 (access_valid
      && access.space == SP_THREE && r.ctrl.continuous_idle_sp37)
      |=> s_gap_then_access(ext_bus.select_n.space_three_select_n))
    else $error("repeated space 3 access did not get exactly one idle cycle");

  AST_SP7_TO_SP3_GAP: assert property (s_end_in(SP_SEVEN) ##0 (access_valid
      && access.space == SP_THREE && r.ctrl.continuous_idle_sp37)
      |=> s_gap_then_access(ext_bus.select_n.space_three_select_n))
    else $error("space 3 after space 7 did not get exactly one idle cycle");

  AST_CW_OFF_NO_GAP: assert property (s_end_in(SP_THREE) ##0 (r.prev.write
      && access_valid && $past(access_valid) && !access.write
      && access.space == SP_SEVEN && !r.ctrl.continuous_idle_sp37)
      |=> !ext_bus.select_n.space_seven_select_n)
    else $error("idle cycle inserted with continuous bit clear");

  AST_CTRL_RESET: assert property (disable iff (1'b0)
      !aresetn |=> r.ctrl == ctrl_s'(CTRL_RESET))
    else $error("control fields not at reset value after reset");

  AST_TAKE_AFTER_GAP: assert property (take |-> gap_need <= r.elapsed)
    else $error("access started before the required idle cycles");

  AST_SP04_WRITE_GAP: assert property (s_rd_end(GRP_04) ##0 (access_valid
      && access.write && access.space[GRP_W-1:0] == GRP_04
      && {r.ctrl.idle_count_sp04_hi, r.ctrl.idle_count_sp04_lo} == 2'h2)
      |=> quiet [*2] ##1 !quiet)
    else $error("write after space 0/4 read did not get two idle cycles");

  AST_SP15_ZERO_GAP: assert property (s_rd_end(GRP_15) ##0 (access_valid
      && $past(access_valid) && access.write
      && {r.ctrl.idle_count_sp15_hi, r.ctrl.idle_count_sp15_lo} == 2'h0)
      |=> !quiet)
    else $error("idle cycle inserted after space 1/5 read with code zero");

  AST_SP7_REPEAT_GAP: assert property (s_end_in(SP_SEVEN) ##0 (access_valid
      && access.space == SP_SEVEN && r.ctrl.continuous_idle_sp37)
      |=> s_gap_then_access(ext_bus.select_n.space_seven_select_n))
    else $error("repeated space 7 access did not get exactly one idle cycle");

  AST_STROBE_PAIR: assert property (r.st == ST_ACC1 |=> r.st == ST_ACC2 && !quiet)
    else $error("access strobe did not last two cycles");

  AST_QUIET_AFTER_ACC: assert property (r.st == ST_ACC2 && !take |=> quiet)
    else $error("bus not released after the access ended");

  AST_SELECT_ONE_HOT: assert property (!quiet |-> $onehot(~ext_bus.select_n)
      && ext_bus.read_n != ext_bus.write_n)
    else $error("active bus cycle without one select and one strobe");

endmodule

`default_nettype wire

//--- rtl/idle_insert_pkg.sv
// constants and types shared by the idle-cycle insertion logic
package idle_insert_pkg;

  localparam int BYTE_W = 8;
  localparam int LANE_BITS = 2;
  localparam int CTRL_W = 16;
  localparam int CTRL_LANES = 2;
  localparam int GAP_W = 2;
  localparam int GRP_W = 2;

  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0F80;
  localparam logic [CTRL_W-1:0] CTRL_WR_MASK = 16'h0F80;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam logic [GAP_W-1:0] GAP_MAX = 2'h3;
  localparam logic [GAP_W-1:0] CW_GAP = 2'h1;

  // space pairs share the low bits of the space number
  localparam logic [GRP_W-1:0] GRP_04 = 2'h0;
  localparam logic [GRP_W-1:0] GRP_15 = 2'h1;
  localparam logic [GRP_W-1:0] GRP_37 = 2'h3;

  localparam logic [2:0] SP_ONE = 3'h1;
  localparam logic [2:0] SP_TWO = 3'h2;
  localparam logic [2:0] SP_THREE = 3'h3;
  localparam logic [2:0] SP_SEVEN = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACC1 = 3'h2,
    ST_ACC2 = 3'h4
  } state_e;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic idle_count_sp15_hi;
    logic idle_count_sp15_lo;
    logic idle_count_sp04_hi;
    logic idle_count_sp04_lo;
    logic continuous_idle_sp37;
    logic [6:0] rsvd_lo;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] space;
    logic write;
  } access_req_s;

  typedef struct packed {
    logic space_seven_select_n;
    logic space_six_select_n;
    logic space_five_select_n;
    logic space_four_select_n;
    logic space_three_select_n;
    logic space_two_select_n;
    logic space_one_select_n;
    logic space_zero_select_n;
  } space_select_s;

  typedef struct packed {
    space_select_s select_n;
    logic read_n;
    logic write_n;
  } ext_bus_s;

  localparam ext_bus_s EXT_QUIET = '1;

endpackage

//--- rtl/idle_gap_calc.sv
// idle cycle count needed between the previous and the next access
`timescale 1ns/10ps
`default_nettype none

module idle_gap_calc
  import idle_insert_pkg::*;
(
  input wire logic prev_valid,
  input wire access_req_s prev,
  input wire access_req_s next_acc,
  input wire ctrl_s ctrl,
  output logic [GAP_W-1:0] gap
);

  logic [GAP_W-1:0] iw;
  logic [GAP_W-1:0] cw;
  logic [GRP_W-1:0] pg;
  logic [GRP_W-1:0] ng;

  always_comb begin
    pg = prev.space[GRP_W-1:0];
    ng = next_acc.space[GRP_W-1:0];
    iw = '0;
    cw = '0;
    if (prev_valid && !prev.write && pg == GRP_15) begin
      if ((next_acc.write && ng == GRP_15) || ng != GRP_15) begin
        iw = {ctrl.idle_count_sp15_hi, ctrl.idle_count_sp15_lo};
      end
    end
    if (prev_valid && !prev.write && pg == GRP_04) begin
      if ((next_acc.write && ng == GRP_04) || ng != GRP_04) begin
        iw = {ctrl.idle_count_sp04_hi, ctrl.idle_count_sp04_lo};
      end
    end
    if (prev_valid && pg == GRP_37 && ng == GRP_37 && ctrl.continuous_idle_sp37) begin
      cw = CW_GAP;
    end
    gap = (iw > cw) ? iw : cw;
  end

endmodule

`default_nettype wire

//--- tb/ext_bus_observer.sv
// observer standing in for the devices on the chip-select spaces
`timescale 1ns/10ps
`default_nettype none
module ext_bus_observer
  import idle_insert_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ext_bus_s ext_bus,
  output logic ev_valid,
  output logic [2:0] ev_space,
  output logic ev_write,
  output logic ev_bad,
  output logic [7:0] ev_gap
);
  logic [7:0] quiet;
  logic [1:0] act;
  logic [7:0] sel;
  assign sel = ~ext_bus.select_n;
  function automatic logic [2:0] enc(input logic [7:0] s);
    enc = 3'h0;
    for (int k = 0; k < 8; k++)
      if (s[k]) enc = k[2:0];
  endfunction
  // a new access starts after quiet cycles or after two strobe cycles
  always @(posedge aclk) begin
    ev_valid <= 1'b0;
    if (!aresetn) begin
      quiet <= 8'h00;
      act <= 2'h0;
    end else if (ext_bus === EXT_QUIET) begin
      quiet <= quiet + 8'h01;
      act <= 2'h0;
    end else begin
      act <= (act == 2'h1) ? 2'h2 : 2'h1;
      if (act != 2'h1) begin
        ev_valid <= 1'b1;
        ev_gap <= quiet;
        ev_space <= enc(sel);
        ev_write <= ~ext_bus.write_n;
        ev_bad <= ($countones(sel) != 1) || (ext_bus.read_n == ext_bus.write_n);
        quiet <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench: idle fields against a gap model
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top
  import idle_insert_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic access_valid, access_ready, ev_valid, ev_write, ev_bad;
  logic [7:0] awaddr, araddr, ev_gap;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] ev_space;
  access_req_s access;
  ext_bus_s ext_bus;
  int n_errors = 0, n_checks = 0, seed = 32'hefb7, cyc = 0, pv_sp = 0, pv_wr = 0, e;
  int eq[$];

  ext_bus_idle_cycle_insert dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .access_valid(access_valid),
    .access(access), .access_ready(access_ready), .ext_bus(ext_bus));
  ext_bus_observer mon_u (.aclk(aclk), .aresetn(aresetn), .ext_bus(ext_bus),
    .ev_valid(ev_valid), .ev_space(ev_space), .ev_write(ev_write), .ev_bad(ev_bad),
    .ev_gap(ev_gap));

  ////////////////////////////////////////////////////////////////////////////
  function automatic int gap_of(int ctl, int ps, int pw, int ns, int nw);
    int g;
    g = 0;
    if (pw == 0 && ps % 4 < 2 && (ns % 4 != ps % 4 || nw == 1))
      g = (ps % 4 == 1) ? (ctl >> 10) & 3 : (ctl >> 8) & 3;
    if (ps % 4 == 3 && ns % 4 == 3 && ((ctl >> 7) & 1) == 1)
      g = (g > 1) ? g : 1;
    return g;
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  // one request held until taken; the queue gets its space, direction and gap
  task automatic send(input int ctl, input int s, input int w, input int first);
    access <= {s[2:0], w[0]};
    access_valid <= 1'b1;
    eq.push_back(((first != 0) ? 0 : gap_of(ctl, pv_sp, pv_wr, s, w) + 1) * 16 + s * 2 + w);
    pv_sp = s;
    pv_wr = w;
    do @(posedge aclk); while (access_ready !== 1'b1);
  endtask

  // requests held back to back so that only the inserted gap separates them
  task automatic run_seq(input int ctl, input int n);
    for (int i = 0; i < n; i++) begin
      send(ctl, {$random(seed)} % 8, {$random(seed)} % 2, i == 0);
    end
    access_valid <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (ev_valid === 1'b1) begin
      `CHK("queued", 1'b1, eq.size() > 0)
      e = (eq.size() > 0) ? eq.pop_front() : 0;
      `CHK("space", e[3:1], ev_space)
      `CHK("write", e[0], ev_write)
      if (e >= 16)
        `CHK("gap", 8'((e >> 4) - 1), ev_gap)
      `CHK("strobes", 1'b0, ev_bad)
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up;
    end
  end

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    int d;
    logic [1:0] r;
    logic [31:0] q;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    access_valid = 1'b0;
    access = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(8'h04, 32'h00000000, r);
    `CHK("status bresp", RESP_OKAY, r)
    rd(8'h00, q, r);
    `CHK("ctrl reset", 32'h00000F80, q)
    rd(8'h08, q, r);
    `CHK("unmapped rresp", RESP_DECERR, r)
    wr(8'h0C, 32'hFFFFFFFF, r);
    `CHK("unmapped bresp", RESP_DECERR, r)
    // every idle code of both pairs with the continuous bit clear and set
    for (int c = 0; c < 32; c++) begin
      d = $random(seed);
      d[11:7] = c[4:0];
      wr(8'h00, d, r);
      `CHK("bresp", RESP_OKAY, r)
      rd(8'h00, q, r);
      `CHK("ctrl", 32'(d & 32'h00000F80), q)
      run_seq(d, 14);
      rd(8'h04, q, r);
      `CHK("status", 32'(32'h000000F0 + pv_sp * 2 + pv_wr), q)
    end
    // directed pairs reaching every idle source, with space 1/5 codes 3 and 0 and space 0/4 code 2 only
    wr(8'h00, 32'h00000E80, r);
    `CHK("bresp", RESP_OKAY, r)
    send(32'hE80, 1, 0, 1);
    send(32'hE80, 1, 1, 0);
    send(32'hE80, 0, 0, 0);
    send(32'hE80, 4, 1, 0);
    send(32'hE80, 0, 0, 0);
    send(32'hE80, 2, 0, 0);
    send(32'hE80, 3, 1, 0);
    send(32'hE80, 3, 0, 0);
    send(32'hE80, 7, 1, 0);
    send(32'hE80, 7, 0, 0);
    send(32'hE80, 3, 0, 0);
    run_seq(32'hE80, 0);
    wr(8'h00, 32'h00000200, r);
    `CHK("bresp", RESP_OKAY, r)
    send(32'h200, 3, 1, 1);
    send(32'h200, 7, 0, 0);
    send(32'h200, 5, 0, 0);
    send(32'h200, 5, 1, 0);
    run_seq(32'h200, 0);
    wrap_up;
  end
endmodule
`default_nettype wire
